//--- logic/chan_support.sv
/*
 Channel support block: two rate generators, clock recovery loop,
 prescalers, test paths, prioritized interrupt with daisy chain and
 vector, DMA requests and fly-by strobes, bus setup and pointer access.
 Assumes a single hclk domain; pins are asynchronous and synchronised here.
*/
// Added by the designer: register access over AHB-Lite and the register offsets.
`default_nettype none
// Notes on behaviour
// - Rate generators: 16-bit counter, reload, toggle points
// - New constant takes effect at next reload
// - Output equals input over constant plus one
// - Recovery loop from x8/x16/x32 reference
// - Transitions adjust the next counting cycle
// - Two 5-bit prescalers divide by 4..32
// - Loopback and echo test paths
// - Vector with three bits giving type
// - Request needs pending, enables, master enable
// - Interrupt only while chain_in high
// - In service blocks lower and chain_out
// - In service set only when unblocked acknowledge
// - Fixed priority from receive status down
// - Six receive and six transmit status causes
// - Data interrupts from FIFO level thresholds
// - Six pin edges, selectable edge, enable
// - Four device status causes enabled separately
// - DMA requests follow FIFO levels
// - Acknowledges act as dedicated FIFO strobes
// - First write after reset sets bus setup
// - Multiplexed address latch, shift, data select
// - Pointer cleared after access, data keeps it
module chan_support
	import chan_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	input  wire logic                  mux_bus,
	input  wire logic                  addr_strobe_n,
	input  wire logic [7:0]            ad_bus,
	input  wire logic                  data_or_command_sel,
	input  wire chan_pkg::pins_t       pins_in,
	input  wire logic                  serial_in,
	input  wire logic                  ref_clk_in,
	input  wire logic                  tx_serial,
	output logic                       rx_serial,
	output logic                       serial_out,
	input  wire chan_pkg::chan_events_t events_in,
	input  wire chan_pkg::fifo_levels_t levels_in,
	output logic                       rate_out0,
	output logic                       rate_out1,
	output logic                       pre_out0,
	output logic                       pre_out1,
	output logic                       rec_clk,
	input  wire logic                  chain_in,
	output logic                       chain_out,
	output logic                       irq_out_n,
	input  wire logic                  int_ack,
	output logic [7:0]                 vector_out,
	output logic                       vector_valid,
	output logic                       rx_dma_request_n,
	output logic                       tx_dma_request_n,
	input  wire logic                  rx_dma_ack_n,
	input  wire logic                  tx_dma_ack_n,
	output logic                       fifo_rd_strobe,
	output logic                       fifo_wr_strobe,
	output logic [4:0]                 reg_sel,
	output logic                       reg_sel_valid
);
	import chan_pkg::*;

	// ==========================================================
	// Helpers
	// Divide select to terminal count of a 5-bit prescaler
	function automatic logic [4:0] pre_term(input logic [1:0] s);
		pre_term = 5'((6'd4 << s) - 6'd1);
	endfunction
	// Rising edge of a synchronised level
	function automatic logic rise(input logic now, input logic old);
		rise = now & ~old;
	endfunction

	// ==========================================================
	// Pin synchronisers (two flops before any logic)
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q; // Stage one, stage two, history
	logic [NSYNC-1:0] raw;
	assign raw = {ref_clk_in, serial_in, rx_dma_ack_n, tx_dma_ack_n, addr_strobe_n,
		pins_in.rx_clock_pin, pins_in.tx_clock_pin,
		pins_in.carrier_detect_pin, pins_in.clear_to_send_pin};
	// Two flop chain then an edge history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	logic ref_tick, rx_dma_ack_n_fall, tx_dma_ack_n_fall, as_fall;
	assign ref_tick   = rise(s2_q[8], s3_q[8]);
	assign rx_dma_ack_n_fall = rise(s3_q[6], s2_q[6]);
	assign tx_dma_ack_n_fall = rise(s3_q[5], s2_q[5]);
	assign as_fall    = rise(s3_q[4], s2_q[4]);

	// ==========================================================
	// Register file
	logic [15:0] tc0_q, tc1_q;          // Time constants
	logic [31:0] clkctl_q, irqctl_q, suben_q, ioedge_q, hwcfg_q;
	logic [7:0]  fifolvl_rx_q, fifolvl_tx_q;
	logic [7:0]  bussetup_q;
	logic        setup_done_q;          // First write consumed
	logic [4:0]  pointer_q;
	logic [5:0]  pend_q, ius_q;
	// Address phase capture
	logic        ph_q, ph_wr_q;
	logic [7:0]  ph_addr_q;
	logic        take;
	assign take = hsel & hready & htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q      <= 1'b0;
			ph_wr_q   <= 1'b0;
			ph_addr_q <= '0;
		end else begin
			ph_q      <= take;
			ph_wr_q   <= take & hwrite;
			ph_addr_q <= take ? haddr[7:0] : ph_addr_q;
		end
	end
	logic wr_en, rd_en;
	assign wr_en = ph_q & ph_wr_q;
	assign rd_en = ph_q & ~ph_wr_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	// Setup write goes to bus_setup_reg whatever the address
	logic reg_wr;
	assign reg_wr = wr_en & setup_done_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setup_done_q <= 1'b0;
			bussetup_q   <= '0;
		end else if (wr_en && !setup_done_q) begin
			setup_done_q <= 1'b1;
			bussetup_q   <= hwdata[7:0];
		end
	end
	// Configuration writes, only after setup
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tc0_q <= RST_TC;
			tc1_q <= RST_TC;
			clkctl_q <= RST_WORD;
			irqctl_q <= RST_WORD;
			suben_q  <= RST_WORD;
			ioedge_q <= RST_WORD;
			hwcfg_q  <= RST_WORD;
			fifolvl_rx_q <= '0;
			fifolvl_tx_q <= '0;
		end else if (reg_wr) begin
			case (ph_addr_q)
				OFF_TC0:    tc0_q <= hwdata[15:0];   // Accepted any time after setup
				OFF_TC1:    tc1_q <= hwdata[15:0];
				OFF_CLKCTL: clkctl_q <= hwdata;
				OFF_IRQCTL: irqctl_q <= hwdata;
				OFF_SUBEN:  suben_q  <= hwdata;
				OFF_IOEDGE: ioedge_q <= hwdata;
				OFF_HWCFG:  hwcfg_q  <= hwdata;
				OFF_FIFOLVL: begin
					fifolvl_rx_q <= hwdata[7:0];
					fifolvl_tx_q <= hwdata[15:8];
				end
				default: ;                           // Others ignored
			endcase
		end
	end
	// Pointer: written, then cleared by the next access to a register other than pointer or data
	logic mux_cycle;
	assign mux_cycle = mux_bus & as_fall & setup_done_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pointer_q <= '0;
		end else if (reg_wr && ph_addr_q == OFF_POINTER) begin
			pointer_q <= hwdata[4:0];
		end else if (ph_q && setup_done_q && ph_addr_q != OFF_POINTER
			&& ph_addr_q != OFF_DATA && !data_or_command_sel) begin
			pointer_q <= '0;
		end
	end
	// Selected channel register: pointer or latched mux address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reg_sel       <= '0;
			reg_sel_valid <= 1'b0;
		end else if (mux_cycle) begin
			// Data select overrides the latched address
			reg_sel <= data_or_command_sel ? 5'h18 :
				(bussetup_q[BUS_SHIFT_BIT] ? ad_bus[7:3] : ad_bus[6:2]);
			reg_sel_valid <= 1'b1;
		end else if (ph_q && setup_done_q && !mux_bus) begin
			reg_sel <= data_or_command_sel ? 5'h18 : pointer_q;
			reg_sel_valid <= 1'b1;
		end else begin
			reg_sel_valid <= 1'b0;
		end
	end

	// ==========================================================
	// Rate generators
	logic [15:0] cnt0_q, cnt1_q;
	logic [15:0] ld0_q, ld1_q;           // Constant in use until reload
	logic        zero0, zero1;
	assign zero0 = (cnt0_q == 16'h0000);
	assign zero1 = (cnt1_q == 16'h0000);
	// Down count, reload, toggle at half and zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt0_q <= RST_TC; cnt1_q <= RST_TC;
			ld0_q  <= RST_TC; ld1_q  <= RST_TC;
			rate_out0 <= 1'b0; rate_out1 <= 1'b0;
		end else begin
			cnt0_q <= zero0 ? tc0_q : cnt0_q - 16'h0001;
			ld0_q  <= zero0 ? tc0_q : ld0_q;
			cnt1_q <= zero1 ? tc1_q : cnt1_q - 16'h0001;
			ld1_q  <= zero1 ? tc1_q : ld1_q;
			// Period is constant plus one input clocks
			if (zero0 || (cnt0_q == (ld0_q >> 1) && ld0_q != 16'h0000)) begin
				rate_out0 <= ~rate_out0;
			end
			if (zero1 || (cnt1_q == (ld1_q >> 1) && ld1_q != 16'h0000)) begin
				rate_out1 <= ~rate_out1;
			end
		end
	end

	// ==========================================================
	// Prescalers
	logic [4:0] pre0_q, pre1_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre0_q <= RST_PRE; pre1_q <= RST_PRE;
			pre_out0 <= 1'b0; pre_out1 <= 1'b0;
		end else begin
			pre0_q <= (pre0_q >= pre_term(clkctl_q[CLK_PRE0_LSB +: 2])) ? RST_PRE
				: pre0_q + 5'd1;
			pre1_q <= (pre1_q >= pre_term(clkctl_q[CLK_PRE1_LSB +: 2])) ? RST_PRE
				: pre1_q + 5'd1;
			// Three-bit index so divide by 32 reaches bit four
			pre_out0 <= pre0_q[3'(clkctl_q[CLK_PRE0_LSB +: 2]) + 3'd1];
			pre_out1 <= pre1_q[3'(clkctl_q[CLK_PRE1_LSB +: 2]) + 3'd1];
		end
	end

	// ==========================================================
	// Clock recovery loop on reference ticks
	logic [5:0] dp_cnt_q, nominal;
	logic       dp_adj_q, dp_dir_q, data_prev_q, sync_q, sync_ev;
	always_comb begin
		case (clkctl_q[CLK_REF_LSB +: 2])
			2'd0:    nominal = REF_X8;
			2'd1:    nominal = REF_X16;
			default: nominal = REF_X32;
		endcase
	end
	// Transition seen: remember, apply in following cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_cnt_q <= '0; dp_adj_q <= 1'b0; dp_dir_q <= 1'b0;
			data_prev_q <= 1'b0; rec_clk <= 1'b0; sync_q <= 1'b0;
		end else if (ref_tick) begin
			data_prev_q <= s2_q[7];
			if (s2_q[7] != data_prev_q) begin
				dp_adj_q <= 1'b1;
				dp_dir_q <= (dp_cnt_q < (nominal >> 1)); // Late or early edge
				sync_q   <= 1'b1;
			end
			if (dp_cnt_q >= nominal - 6'd1) begin
				// Next cycle shortened or lengthened by one
				dp_cnt_q <= dp_adj_q ? (dp_dir_q ? 6'd1 : 6'd63) : 6'd0;
				dp_adj_q <= 1'b0;
			end else begin
				dp_cnt_q <= dp_cnt_q + 6'd1;
			end
			rec_clk <= (dp_cnt_q < (nominal >> 1));
		end
	end
	logic sync_prev_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) sync_prev_q <= 1'b0;
		else sync_prev_q <= sync_q;
	end
	assign sync_ev = sync_q & ~sync_prev_q;

	// ==========================================================
	// Test paths
	assign rx_serial  = clkctl_q[CLK_LOOP_BIT] ? tx_serial : s2_q[7];
	assign serial_out = clkctl_q[CLK_ECHO_BIT] ? s2_q[7] : tx_serial;

	// ==========================================================
	// Interrupt groups
	logic [5:0] io_now, io_old, io_hit;
	logic       rxd_lvl, txd_lvl;
	logic       rx_req_old_q, tx_req_old_q; // Request history for edges
	assign rxd_lvl = levels_in.rx_fill > fifolvl_rx_q[5:0];
	assign txd_lvl = levels_in.tx_empty < fifolvl_tx_q[5:0];
	assign io_now = {s2_q[3], s2_q[2], rx_dma_request_n, tx_dma_request_n,
		s2_q[1], s2_q[0]};
	assign io_old = {s3_q[3], s3_q[2], rx_req_old_q, tx_req_old_q, s3_q[1], s3_q[0]};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_req_old_q <= 1'b1; tx_req_old_q <= 1'b1;
		end else begin
			rx_req_old_q <= rx_dma_request_n; tx_req_old_q <= tx_dma_request_n;
		end
	end
	// Per pin: enable, rising, falling
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			io_hit[i] = ioedge_q[i] & ((ioedge_q[8+i] & io_now[i] & ~io_old[i])
				| (ioedge_q[16+i] & ~io_now[i] & io_old[i]));
		end
	end
	logic [5:0] cause;
	assign cause[G_RXS] = |(events_in.rx_status & suben_q[5:0]);
	assign cause[G_RXD] = rxd_lvl;
	assign cause[G_TXS] = |(events_in.tx_status & suben_q[13:8]);
	assign cause[G_TXD] = txd_lvl;
	assign cause[G_IOS] = |io_hit;
	assign cause[G_DEV] = |({events_in.cnt_fifo_ovf, sync_ev, zero1, zero0}
		& suben_q[19:16]);
	// Internal chain: requests and in service of higher groups block lower
	logic [5:0] req, blk;
	logic       channel_master_enable, any_req, ack_grant;
	logic [2:0] win;
	assign channel_master_enable = irqctl_q[IRQ_MIE_BIT];
	always_comb begin
		blk = '0;
		req = '0;
		win = 3'd0;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			req[g] = pend_q[g] & irqctl_q[IRQ_EN_LSB+g] & channel_master_enable & ~blk[g];
			if (g < NUM_GROUPS-1) blk[g+1] = blk[g] | ius_q[g] | req[g];
		end
		for (int g = NUM_GROUPS-1; g >= 0; g--) begin
			if (req[g]) win = 3'(g);
		end
	end
	assign any_req   = |req;
	assign ack_grant = int_ack & chain_in & any_req;
	assign irq_out_n = ~(any_req & chain_in);
	assign chain_out = chain_in & ~(|ius_q) & ~any_req;
	// Pending set wins over software clear; in service on granted ack
	logic [5:0] clr;
	assign clr = (reg_wr && ph_addr_q == OFF_IRQSTAT) ? hwdata[5:0] : 6'h00;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= '0; ius_q <= '0;
		end else begin
			pend_q <= (pend_q & ~clr) | cause;
			for (int g = 0; g < NUM_GROUPS; g++) begin
				if (ack_grant && win == 3'(g)) ius_q[g] <= 1'b1;
				else if (reg_wr && ph_addr_q == OFF_IRQSTAT && hwdata[8+g])
					ius_q[g] <= 1'b0;
			end
		end
	end
	// Vector with three type bits replaced
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_out <= '0; vector_valid <= 1'b0;
		end else begin
			vector_valid <= ack_grant;
			if (ack_grant) begin
				vector_out <= irqctl_q[IRQ_VIS_BIT] ?
					{irqctl_q[IRQ_VEC_LSB+4 +: 4], win, irqctl_q[IRQ_VEC_LSB]} :
					irqctl_q[IRQ_VEC_LSB +: 8];
			end
		end
	end

	// ==========================================================
	// DMA
	assign rx_dma_request_n = ~rxd_lvl;
	assign tx_dma_request_n = ~txd_lvl;
	// Fly-by acknowledge needs no select
	assign fifo_rd_strobe = hwcfg_q[HW_RX_DMA_ACK_N_BIT] & rx_dma_ack_n_fall;
	assign fifo_wr_strobe = hwcfg_q[HW_TX_DMA_ACK_N_BIT] & tx_dma_ack_n_fall;

	// ==========================================================
	// Read mux
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= RST_WORD;
		end else if (take && !hwrite) begin
			case (haddr[7:0])
				OFF_TC0:      hrdata <= {cnt0_q, tc0_q};
				OFF_TC1:      hrdata <= {cnt1_q, tc1_q};
				OFF_CLKCTL:   hrdata <= clkctl_q;
				OFF_IRQCTL:   hrdata <= irqctl_q;
				OFF_IRQSTAT:  hrdata <= {16'h0000, 2'b00, ius_q, 2'b00, pend_q};
				OFF_SUBEN:    hrdata <= suben_q;
				OFF_FIFOLVL:  hrdata <= {16'h0000, fifolvl_tx_q, fifolvl_rx_q};
				OFF_IOEDGE:   hrdata <= ioedge_q;
				OFF_BUSSETUP: hrdata <= {23'h0, setup_done_q, bussetup_q};
				OFF_POINTER:  hrdata <= {27'h0, pointer_q};
				OFF_HWCFG:    hrdata <= hwcfg_q;
				default:      hrdata <= RST_WORD;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- common/chan_pkg.sv
/*
 Package for the serial channel support block: register offsets, reset
 values, field positions and carrier structs.
 Assumes a single 250 MHz hclk domain and an AHB-Lite register bus.
*/
`default_nettype none
package chan_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_TC0      = 8'h00; // Rate gen zero constant
	localparam logic [7:0] OFF_TC1      = 8'h04; // Rate gen one constant
	localparam logic [7:0] OFF_CLKCTL   = 8'h08; // Prescalers, loop, test
	localparam logic [7:0] OFF_IRQCTL   = 8'h0C; // Master/group enables, vector
	localparam logic [7:0] OFF_IRQSTAT  = 8'h10; // Pending/in service, write 1 clr
	localparam logic [7:0] OFF_SUBEN    = 8'h14; // Sub-source enables
	localparam logic [7:0] OFF_FIFOLVL  = 8'h18; // Rx/Tx levels (rx_irq_ctrl, tx_irq_ctrl)
	localparam logic [7:0] OFF_IOEDGE   = 8'h1C; // Pin edge select and enable
	localparam logic [7:0] OFF_BUSSETUP = 8'h20; // bus_setup_reg readback
	localparam logic [7:0] OFF_POINTER  = 8'h24; // pointer_reg
	localparam logic [7:0] OFF_HWCFG    = 8'h28; // hardware_config_reg
	localparam logic [7:0] OFF_DATA     = 8'h2C; // rx_data_reg / tx_data_reg
	// ==========================================================
	// Reset values
	localparam logic [15:0] RST_TC     = 16'h0000;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [4:0]  RST_PRE    = 5'h00;
	// ==========================================================
	// Field positions
	localparam int CLK_PRE0_LSB = 0;  // 2 bits: /4 /8 /16 /32
	localparam int CLK_PRE1_LSB = 2;
	localparam int CLK_REF_LSB  = 4;  // 2 bits: x8 x16 x32
	localparam int CLK_LOOP_BIT = 6;
	localparam int CLK_ECHO_BIT = 7;
	localparam int IRQ_MIE_BIT  = 0;
	localparam int IRQ_EN_LSB   = 1;  // 6 bits group enables
	localparam int IRQ_VEC_LSB  = 8;  // 8 bits vector
	localparam int IRQ_VIS_BIT  = 16; // Vector includes status
	localparam int BUS_SHIFT_BIT = 0;
	localparam int HW_RX_DMA_ACK_N_BIT = 0;
	localparam int HW_TX_DMA_ACK_N_BIT = 1;
	localparam int NUM_GROUPS   = 6;
	// Group indices, highest priority first
	localparam int G_RXS = 0;
	localparam int G_RXD = 1;
	localparam int G_TXS = 2;
	localparam int G_TXD = 3;
	localparam int G_IOS = 4;
	localparam int G_DEV = 5;
	// ==========================================================
	// Recovery loop counts
	localparam logic [5:0] REF_X8  = 6'd8;
	localparam logic [5:0] REF_X16 = 6'd16;
	localparam logic [5:0] REF_X32 = 6'd32;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [5:0] rx_status;  // Hunt exit, idle, break, cv/eof, parity, overrun
		logic [5:0] tx_status;  // Preamble, idle, abort, eof, crc, underrun
		logic       cnt_fifo_ovf;
	} chan_events_t;
	typedef struct packed {
		logic [5:0] rx_fill;
		logic [5:0] tx_empty;
	} fifo_levels_t;
	typedef struct packed {
		logic rx_clock_pin;
		logic tx_clock_pin;
		logic carrier_detect_pin;
		logic clear_to_send_pin;
	} pins_t;
endpackage
`default_nettype wire

//--- testbench/chan_support_chk.sv
/*
 Checker for the channel support block, on its ports only.
 Assumes one hclk domain; bound at the foot of this file.
*/
`default_nettype none
module chan_support_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic chain_in,
	input wire logic chain_out,
	input wire logic irq_out_n,
	input wire logic int_ack,
	input wire logic vector_valid,
	input wire logic rx_dma_ack_n,
	input wire logic tx_dma_ack_n,
	input wire logic fifo_rd_strobe,
	input wire logic fifo_wr_strobe,
	input wire logic reg_sel_valid
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========================================================
	// Cycles since each acknowledge was last seen low
	logic [3:0] rx_age_q;
	logic [3:0] tx_age_q;
	// Saturates so a stale strobe long after an ack is caught
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_age_q <= 4'hF;
			tx_age_q <= 4'hF;
		end else begin
			rx_age_q <= !rx_dma_ack_n ? 4'h0 : rx_age_q + 4'(rx_age_q != 4'hF);
			tx_age_q <= !tx_dma_ack_n ? 4'h0 : tx_age_q + 4'(tx_age_q != 4'hF);
		end
	end
	// ==========================================================
	// Daisy chain and vector
	property p_irq_chain; !chain_in |-> irq_out_n; endproperty
	a_irq_chain: assert property (p_irq_chain) else $error("request while chain blocked");
	property p_chain_out; !chain_in |-> !chain_out; endproperty
	a_chain_out: assert property (p_chain_out) else $error("chain_out high while blocked");
	property p_ack_vec; int_ack && chain_in && !irq_out_n |-> ##[1:2] vector_valid; endproperty
	a_ack_vec: assert property (p_ack_vec) else $error("no vector after acknowledge");
	property p_vec_pulse; vector_valid |=> !vector_valid; endproperty
	a_vec_pulse: assert property (p_vec_pulse) else $error("vector_valid longer than one cycle");
	property p_blocked_ack; (!chain_in) [*3] |-> !vector_valid; endproperty
	a_blocked_ack: assert property (p_blocked_ack) else $error("vector while blocked");
	// ==========================================================
	// Fly-by strobes and address latch
	property p_rd_strobe; fifo_rd_strobe |-> rx_age_q <= 4'd5; endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe without ack");
	property p_wr_strobe; fifo_wr_strobe |-> tx_age_q <= 4'd5; endproperty
	a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe without ack");
	property p_rd_once; fifo_rd_strobe |=> !fifo_rd_strobe; endproperty
	a_rd_once: assert property (p_rd_once) else $error("read strobe repeated");
	property p_sel_pulse; reg_sel_valid |=> !reg_sel_valid; endproperty
	a_sel_pulse: assert property (p_sel_pulse) else $error("address latch pulse too long");
	c_vec: cover property (vector_valid);
	c_strobe: cover property (fifo_rd_strobe);
	c_irq: cover property (!irq_out_n ##1 irq_out_n);
endmodule
bind chan_support chan_support_chk chk_i (.*);
`default_nettype wire

//--- testbench/dma_chan.sv
/*
 Model of a DMA channel answering requests by fly-by acknowledge.
 Assumes the block's hclk; LAG sets the answer delay.
*/
`default_nettype none
module dma_chan #(
	parameter int LAG = 1
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic req_n,
	output logic      ack_n
);
	int st_q; // Zero idle, then lag, strobe and gap
	// ==========================================================
	// One transfer per pass, repeated while the request stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= 0;
			ack_n <= 1'b1;
		end else begin
			// Answer only a standing request
			if (st_q == 0 && !req_n) begin
				st_q <= 1;
			end else if (st_q != 0) begin
				st_q <= (st_q == LAG + 6) ? 0 : st_q + 1;
			end
			// Strobe three cycles, never with a chip select
			ack_n <= !(st_q > LAG && st_q <= LAG + 3);
		end
	end
endmodule
`default_nettype wire

//--- testbench/chan_support_tb.sv
/*
 Self-checking bench for the channel support block.
 Assumes hclk drives every counter and AHB-Lite with zero wait states.
*/
`default_nettype none
module chan_support_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import chan_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, cnt_on = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r, exp_m [16] = '{default: '0};
	logic [1:0] htrans = '0;
	logic [7:0] ad_bus = '0, vector_out, ra [6];
	logic [4:0] reg_sel;
	pins_t pins_in = '0;
	chan_events_t ev = '0;
	fifo_levels_t lv = '0;
	logic mux_bus = 0, addr_strobe_n = 1, serial_in = 0, ref_clk_in = 0, tx_serial = 0;
	logic chain_in = 1, int_ack = 0, rx_p = 1, tx_p = 1;
	logic rx_serial, serial_out, rate_out0, rate_out1, pre_out0, pre_out1, rec_clk, chain_out;
	logic irq_out_n, vector_valid, rx_dma_request_n, tx_dma_request_n, rx_dma_ack_n;
	logic tx_dma_ack_n, fifo_rd_strobe, fifo_wr_strobe, reg_sel_valid;
	int n_fail = 0, tests_run = 0, cyc = 0, acks = 0, strobes = 0, sels = 0, n, p, g, k;
	wire logic [3:0] mon = {rate_out1, rate_out0, pre_out1, pre_out0};
	chan_support chan_support_i (.*, .hsize(3'b010), .hready(hreadyout),
		.data_or_command_sel(1'b0), .events_in(ev), .levels_in(lv));
	dma_chan #(.LAG(1)) rx_dma_i (.hclk, .hresetn, .req_n(rx_dma_request_n), .ack_n(rx_dma_ack_n));
	dma_chan #(.LAG(4)) tx_dma_i (.hclk, .hresetn, .req_n(tx_dma_request_n), .ack_n(tx_dma_ack_n));
	always #2 hclk = ~hclk;
	// ==========================================================
	// Bits kept by each register; zero means unmapped
	function automatic logic [31:0] msk(input logic [7:0] a);
		msk = (a == OFF_FIFOLVL) ? 32'h0000_FFFF : (a == OFF_POINTER) ? 32'h0000_001F
			: (a == 8'h3C) ? '0 : '1;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		tests_run++;
		if (got !== e) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, e);
		end
	endtask
	// One AHB-Lite single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		exp_m[a[5:2]] = d & msk(a);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, '0);
		chk(r, exp_m[a[5:2]]);
	endtask
	// Cycles between second and third rise of a monitored output
	task automatic per(input int i, output int q);
		logic l;
		int c = 0, e = 0;
		q = 0;
		l = mon[i];
		repeat (400) begin
			@(posedge hclk);
			c++;
			if (mon[i] === 1'b1 && l === 1'b0) begin
				e++;
				if (e == 3) q = c;
				c = 0;
			end
			l = mon[i];
		end
	endtask
	task final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// Reference clock, pin noise, event counters and timeout
	always @(posedge hclk) begin
		cyc++;
		if (cyc % 3 == 0) ref_clk_in <= ~ref_clk_in;
		if (cyc % 16 == 0) pins_in <= pins_t'(4'($urandom()));
		if (reg_sel_valid === 1'b1) sels++;
		if (cnt_on) begin
			acks += int'(rx_dma_ack_n === 1'b0 && rx_p) + int'(tx_dma_ack_n === 1'b0 && tx_p);
			strobes += int'(fifo_rd_strobe === 1'b1) + int'(fifo_wr_strobe === 1'b1);
		end
		rx_p = rx_dma_ack_n;
		tx_p = tx_dma_ack_n;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		ra = '{OFF_CLKCTL, OFF_FIFOLVL, OFF_IOEDGE, OFF_SUBEN, OFF_HWCFG, 8'h3C};
		void'($urandom(93171));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, OFF_IRQCTL, 32'h0000_0001);
		bus(1'b0, OFF_BUSSETUP, '0);
		chk(r & 32'h1, 32'h1);
		rd(OFF_IRQCTL);
		foreach (ra[i]) begin
			wr(ra[i], $urandom());
			rd(ra[i]);
		end
		wr(OFF_POINTER, 32'h0000_0005);
		bus(1'b0, OFF_POINTER, '0);
		chk(r, 32'h0000_0005);
		rd(OFF_IRQCTL);
		exp_m[9] = '0;
		rd(OFF_POINTER);
		// Rate generators: full output wave is constant plus one
		for (k = 0; k < 2; k++) begin
			n = $urandom_range(40, 2);
			wr(OFF_TC0 + 8'(4 * k), 32'(n));
			per(2 + k, p);
			chk(p, n + 1);
		end
		for (k = 0; k < 4; k++) begin
			wr(OFF_CLKCTL, 32'(k | ((3 - k) << 2)));
			per(0, p);
			chk(p, 4 << k);
			per(1, p);
			chk(p, 32 >> k);
		end
		wr(OFF_CLKCTL, 32'h0000_0040);
		tx_serial <= 1'b1;
		repeat (2) @(posedge hclk);
		chk(rx_serial, tx_serial);
		wr(OFF_CLKCTL, 32'h0000_0080);
		serial_in <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(serial_out, serial_in);
		// Two groups pending at once; the higher answers first
		wr(OFF_SUBEN, 32'h0000_0101);
		wr(OFF_IRQCTL, 32'h0001_A00B);
		ev.rx_status <= 6'h01;
		ev.tx_status <= 6'h01;
		@(posedge hclk);
		ev <= '0;
		repeat (3) @(posedge hclk);
		chk(irq_out_n, 1'b0);
		chain_in <= 1'b0;
		int_ack <= 1'b1;
		@(posedge hclk);
		int_ack <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({irq_out_n, chain_out, vector_valid}, 3'b100);
		chain_in <= 1'b1;
		for (g = 0; g < 3; g += 2) begin
			@(posedge hclk);
			int_ack <= 1'b1;
			@(posedge hclk);
			int_ack <= 1'b0;
			for (k = 0; vector_valid !== 1'b1 && k < 4; k++) @(posedge hclk);
			chk(vector_out, 8'hA0 | 8'(g << 1));
			wr(OFF_IRQSTAT, 32'h0000_0001 << g);
			@(posedge hclk);
			chk({chain_out, irq_out_n}, 2'b01);
			wr(OFF_IRQSTAT, 32'h0000_0100 << g);
		end
		ev.rx_status <= 6'h02;
		@(posedge hclk);
		ev <= '0;
		repeat (3) @(posedge hclk);
		chk({chain_out, irq_out_n}, 2'b11);
		// Requests at and across the level; partner answers by fly-by
		lv <= {6'd0, 6'd6};
		wr(OFF_FIFOLVL, 32'h0000_0404);
		wr(OFF_HWCFG, 32'h0000_0003);
		repeat (20) @(posedge hclk);
		cnt_on = 1'b1;
		lv <= {6'd5, 6'd3};
		repeat (2) @(posedge hclk);
		chk({rx_dma_request_n, tx_dma_request_n}, 2'b00);
		repeat (60) @(posedge hclk);
		lv <= {6'd4, 6'd4};
		repeat (2) @(posedge hclk);
		chk({rx_dma_request_n, tx_dma_request_n}, 2'b11);
		repeat (20) @(posedge hclk);
		cnt_on = 1'b0;
		chk(strobes, acks);
		chk(acks > 2, 1'b1);
		sels = 0;
		mux_bus <= 1'b1;
		ad_bus <= 8'($urandom());
		addr_strobe_n <= 1'b0;
		repeat (4) @(posedge hclk);
		addr_strobe_n <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(sels, 1);
		chk(reg_sel, ad_bus[7:3]);
		final_report();
	end
endmodule
`default_nettype wire
